// File: hw/isd_ctrl.sv
// interrupt controller with low-supply detector control, registers and vector arbiter
`timescale 1ns/1ps
`default_nettype none

module isd_ctrl
    import isd_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire isd_regreq_t i_reg,
    output logic [7:0] o_reg_rdata,
    input wire logic i_supply_low,
    input wire logic i_sleep,
    input wire logic i_rlvl_enable,
    input wire logic i_ext_pin,
    input wire isd_evt_t i_evt,
    input wire logic i_stack_full,
    input wire logic i_irq_ack,
    output logic o_irq_req,
    output logic [3:0] o_irq_vector,
    output logic o_wake,
    output logic o_detector_on,
    output logic o_bandgap_on,
    output logic [2:0] o_trip_level,
    output logic [12:0] o_trip_mv
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0] trip_lvl_r;
    logic det_en_r;
    logic bg_out_en_r;
    logic low_flag_r;
    logic [1:0] edge_sel_r;
    logic pin_prev_r;
    logic [8:0] flags_r;
    logic [8:0] flags_nxt;
    logic [8:0] en_r;
    logic emi_r;
    logic [LVD_CW-1:0] lvd_cnt_r;
    isd_arb_t arb_r;
    logic [3:0] vec_r;
    logic req_r;
    logic wake_r;
    logic det_on_r;
    logic bg_on_r;
    logic [7:0] rdata_r;
    logic [12:0] trip_mv_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam logic [LVD_CW-1:0] LVD_LAST = LVD_CW'(LVD_CNT - 1);
    localparam logic [LVD_CW-1:0] LVD_SAT = LVD_CW'(LVD_CNT);

    // lowest pending index wins
    function automatic logic [3:0] first_set(input logic [8:0] vec);
        first_set = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (vec[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    // one-hot mask for a source index
    function automatic logic [8:0] src_mask(input logic [3:0] idx);
        src_mask = 9'h000;
        for (int i = 0; i < NSRC; i++) begin
            if (idx == 4'(i)) begin
                src_mask[i] = 1'b1;
            end
        end
    endfunction

    logic wr_sdc, wr_pes, wr_ic1, wr_ic2, wr_ic3;
    logic det_active;
    logic pin_rise, pin_fall, pin_hit;
    logic lvd_set;
    logic ack_take;
    logic [8:0] set_vec;
    logic [8:0] wr_mask;
    logic [8:0] wr_val;
    logic [8:0] ack_clr;
    logic [8:0] pending;

    // ------------------------------------------------------------
    // write strobes and detector gating
    // ------------------------------------------------------------
    assign wr_sdc = i_reg.wr && (i_reg.addr == REG_SDC);
    assign wr_pes = i_reg.wr && (i_reg.addr == REG_PES);
    assign wr_ic1 = i_reg.wr && (i_reg.addr == REG_IC1);
    assign wr_ic2 = i_reg.wr && (i_reg.addr == REG_IC2);
    assign wr_ic3 = i_reg.wr && (i_reg.addr == REG_IC3);
    assign det_active = det_en_r && !i_sleep;

    // pin edges, input is already synchronous to the core clock
    assign pin_rise = i_ext_pin && !pin_prev_r;
    assign pin_fall = !i_ext_pin && pin_prev_r;
    assign pin_hit = (edge_sel_r[0] && pin_rise) || (edge_sel_r[1] && pin_fall);

    // fires once per low excursion, on the cycle the delay completes
    assign lvd_set = low_flag_r && (lvd_cnt_r == LVD_LAST);
    assign ack_take = i_irq_ack && (arb_r == ARB_OFFER);
    assign pending = flags_r & en_r;

    // ------------------------------------------------------------
    // flag set, write and service-clear vectors
    // ------------------------------------------------------------
    always_comb begin
        set_vec = 9'h000;
        set_vec[SRC_PIN] = pin_hit;
        set_vec[SRC_SER] = i_evt.serial;
        set_vec[SRC_LOW] = lvd_set;
        set_vec[SRC_CMPP] = i_evt.cmp_p;
        set_vec[SRC_CMPA] = i_evt.cmp_a;
        set_vec[SRC_EE] = i_evt.eeprom;
        set_vec[SRC_CONV] = i_evt.conv;
        set_vec[SRC_TB0] = i_evt.tb0;
        set_vec[SRC_TB1] = i_evt.tb1;
        wr_mask = 9'h000;
        wr_val = 9'h000;
        if (wr_ic1) begin
            wr_mask[SRC_LOW] = 1'b1;
            wr_mask[SRC_SER] = 1'b1;
            wr_mask[SRC_PIN] = 1'b1;
            wr_val[SRC_LOW] = i_reg.wdata[IC1_LVF_BIT];
            wr_val[SRC_SER] = i_reg.wdata[IC1_SERF_BIT];
            wr_val[SRC_PIN] = i_reg.wdata[IC1_PINF_BIT];
        end
        if (wr_ic2) begin
            wr_mask[SRC_CMPA] = 1'b1;
            wr_mask[SRC_CMPP] = 1'b1;
            wr_mask[SRC_EE] = 1'b1;
            wr_mask[SRC_CONV] = 1'b1;
            wr_val[SRC_CMPA] = i_reg.wdata[IC2_CMPAF_BIT];
            wr_val[SRC_CMPP] = i_reg.wdata[IC2_CMPPF_BIT];
            wr_val[SRC_EE] = i_reg.wdata[IC2_EEF_BIT];
            wr_val[SRC_CONV] = i_reg.wdata[IC2_CONVF_BIT];
        end
        if (wr_ic3) begin
            wr_mask[SRC_TB1] = 1'b1;
            wr_mask[SRC_TB0] = 1'b1;
            wr_val[SRC_TB1] = i_reg.wdata[IC3_TB1F_BIT];
            wr_val[SRC_TB0] = i_reg.wdata[IC3_TB0F_BIT];
        end
        ack_clr = ack_take ? src_mask(vec_r) : 9'h000;
        // a hardware set beats a software or service clear in the same cycle
        flags_nxt = set_vec | (wr_mask & wr_val) | (~wr_mask & flags_r & ~ack_clr);
    end

    // ------------------------------------------------------------
    // supply detector control register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            trip_lvl_r <= SDC_RST[SDC_LVL_LSB +: 3];
            det_en_r <= SDC_RST[SDC_EN_BIT];
            bg_out_en_r <= SDC_RST[SDC_BG_BIT];
        end else if (i_ce && wr_sdc) begin
            trip_lvl_r <= i_reg.wdata[SDC_LVL_LSB +: 3];
            det_en_r <= i_reg.wdata[SDC_EN_BIT];
            bg_out_en_r <= i_reg.wdata[SDC_BG_BIT];
        end
    end

    // comparator result is only meaningful while the detector runs; no glitch filter here
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            low_flag_r <= SDC_RST[SDC_LOW_BIT];
        end else if (i_ce) begin
            low_flag_r <= i_supply_low && det_active;
        end
    end

    // delay counter, restarts on every drop of the low flag
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            lvd_cnt_r <= '0;
        end else if (i_ce) begin
            if (!low_flag_r) begin
                lvd_cnt_r <= '0;
            end else if (lvd_cnt_r != LVD_SAT) begin
                lvd_cnt_r <= lvd_cnt_r + LVD_CW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // pin edge select and pin history
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            edge_sel_r <= PES_RST;
            pin_prev_r <= 1'b0;
        end else if (i_ce) begin
            pin_prev_r <= i_ext_pin;
            if (wr_pes) begin
                edge_sel_r <= i_reg.wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // request flags and enables
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            flags_r <= FLAGS_RST;
        end else if (i_ce) begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            en_r <= ENABLES_RST;
        end else if (i_ce) begin
            if (wr_ic1) begin
                en_r[SRC_LOW] <= i_reg.wdata[IC1_LVE_BIT];
                en_r[SRC_SER] <= i_reg.wdata[IC1_SERE_BIT];
                en_r[SRC_PIN] <= i_reg.wdata[IC1_PINE_BIT];
            end
            if (wr_ic2) begin
                en_r[SRC_CMPA] <= i_reg.wdata[IC2_CMPAE_BIT];
                en_r[SRC_CMPP] <= i_reg.wdata[IC2_CMPPE_BIT];
                en_r[SRC_EE] <= i_reg.wdata[IC2_EEE_BIT];
                en_r[SRC_CONV] <= i_reg.wdata[IC2_CONVE_BIT];
            end
            if (wr_ic3) begin
                en_r[SRC_TB1] <= i_reg.wdata[IC3_TB1E_BIT];
                en_r[SRC_TB0] <= i_reg.wdata[IC3_TB0E_BIT];
            end
        end
    end

    // global enable; a software write in the ack cycle overrides the service clear
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            emi_r <= EMI_RST;
        end else if (i_ce) begin
            if (wr_ic1) begin
                emi_r <= i_reg.wdata[IC1_EMI_BIT];
            end else if (ack_take) begin
                emi_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // vector arbiter: offer one vector, hold it until taken or withdrawn
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            arb_r <= ARB_IDLE;
            vec_r <= SRC_PIN;
            req_r <= 1'b0;
        end else if (i_ce) begin
            case (arb_r)
                ARB_IDLE: begin
                    if (emi_r && !i_stack_full && (|pending)) begin
                        arb_r <= ARB_OFFER;
                        vec_r <= first_set(pending);
                        req_r <= 1'b1;
                    end
                end
                ARB_OFFER: begin
                    // withdraw if the cpu cannot take it any more, rather than stall a stale vector
                    if (ack_take || !emi_r || i_stack_full || !pending[vec_r]) begin
                        arb_r <= ARB_IDLE;
                        req_r <= 1'b0;
                    end
                end
                default: begin
                    arb_r <= ARB_IDLE;
                    req_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // wake, analog enables and trip level outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wake_r <= 1'b0;
            det_on_r <= 1'b0;
            bg_on_r <= 1'b0;
            trip_mv_r <= 13'h000;
        end else if (i_ce) begin
            wake_r <= |flags_r;
            det_on_r <= det_active;
            bg_on_r <= det_en_r || i_rlvl_enable || bg_out_en_r;
            trip_mv_r <= isd_trip_mv(trip_lvl_r);
        end
    end

    // ------------------------------------------------------------
    // register read port, one cycle latency
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rdata_r <= 8'h00;
        end else if (i_ce) begin
            case (i_reg.addr)
                REG_SDC: rdata_r <= {2'h0, low_flag_r, det_en_r, bg_out_en_r, trip_lvl_r};
                REG_PES: rdata_r <= {6'h00, edge_sel_r};
                REG_IC1: rdata_r <= {1'b0, flags_r[SRC_LOW], flags_r[SRC_SER], flags_r[SRC_PIN],
                                     en_r[SRC_LOW], en_r[SRC_SER], en_r[SRC_PIN], emi_r};
                REG_IC2: rdata_r <= {flags_r[SRC_CMPA], flags_r[SRC_CMPP], flags_r[SRC_EE], flags_r[SRC_CONV],
                                     en_r[SRC_CMPA], en_r[SRC_CMPP], en_r[SRC_EE], en_r[SRC_CONV]};
                REG_IC3: rdata_r <= {2'h0, flags_r[SRC_TB1], flags_r[SRC_TB0], 2'h0, en_r[SRC_TB1], en_r[SRC_TB0]};
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_irq_req = req_r;
    assign o_irq_vector = vec_r;
    assign o_wake = wake_r;
    assign o_detector_on = det_on_r;
    assign o_bandgap_on = bg_on_r;
    assign o_trip_level = trip_lvl_r;
    assign o_trip_mv = trip_mv_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    property p_det_sleep;
        i_ce && i_sleep |=> !o_detector_on && !low_flag_r;
    endproperty
    a_det_sleep: assert property (p_det_sleep) else $error("detector active during sleep");

    property p_det_on;
        i_ce && det_en_r && !i_sleep |=> o_detector_on;
    endproperty
    a_det_on: assert property (p_det_on) else $error("enabled detector not on");

    property p_low_flag;
        i_ce && det_active |=> low_flag_r == $past(i_supply_low);
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("low flag does not follow comparator");

    property p_lvd_delay;
        $past(i_ce) && $rose(flags_r[SRC_LOW]) && !$past(wr_ic1) |->
            $past(low_flag_r) && $past(lvd_cnt_r) == LVD_LAST;
    endproperty
    a_lvd_delay: assert property (p_lvd_delay) else $error("low-supply flag set before delay");

    property p_bandgap;
        i_ce && (det_en_r || i_rlvl_enable || bg_out_en_r) |=> o_bandgap_on;
    endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap off while needed");

    property p_pin_edge;
        i_ce && edge_sel_r == 2'h2 && pin_fall |=> flags_r[SRC_PIN];
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("falling edge missed");

    property p_ack_emi;
        i_ce && ack_take && !wr_ic1 |=> !emi_r ##1 !o_irq_req;
    endproperty
    a_ack_emi: assert property (p_ack_emi) else $error("global enable kept after service");

    property p_stack_full;
        i_ce && i_stack_full |=> !o_irq_req;
    endproperty
    a_stack_full: assert property (p_stack_full) else $error("request offered with full stack");

    property p_gate;
        i_ce && arb_r == ARB_IDLE && emi_r && !i_stack_full && (|pending) |=>
            o_irq_req && o_irq_vector == $past(first_set(pending));
    endproperty
    a_gate: assert property (p_gate) else $error("pending request not offered by priority");

    property p_wake;
        i_ce && (|flags_r) |=> o_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("set flag did not wake");

    property p_set_wins;
        i_ce && i_evt.conv && wr_ic2 && !i_reg.wdata[IC2_CONVF_BIT] |=> flags_r[SRC_CONV];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    property p_pes_zero;
        i_ce && i_reg.addr == REG_PES |=> o_reg_rdata[7:2] == 6'h00;
    endproperty
    a_pes_zero: assert property (p_pes_zero) else $error("unimplemented bits not zero");

endmodule

`default_nettype wire

// File: hw/isd_pkg.sv
// shared constants, types and helpers of the interrupt controller with supply detector
package isd_pkg;

    // ------------------------------------------------------------
    // register indices on the cpu data-memory port
    // ------------------------------------------------------------
    localparam logic [2:0] REG_SDC = 3'h0; // supply_detect_control
    localparam logic [2:0] REG_PES = 3'h1; // pin_edge_select
    localparam logic [2:0] REG_IC1 = 3'h2; // irq_control_first
    localparam logic [2:0] REG_IC2 = 3'h3; // irq_control_second
    localparam logic [2:0] REG_IC3 = 3'h4; // irq_control_third

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SDC_LOW_BIT = 5;
    localparam int SDC_EN_BIT = 4;
    localparam int SDC_BG_BIT = 3;
    localparam int SDC_LVL_LSB = 0;
    localparam int IC1_LVF_BIT = 6;
    localparam int IC1_SERF_BIT = 5;
    localparam int IC1_PINF_BIT = 4;
    localparam int IC1_LVE_BIT = 3;
    localparam int IC1_SERE_BIT = 2;
    localparam int IC1_PINE_BIT = 1;
    localparam int IC1_EMI_BIT = 0;
    localparam int IC2_CMPAF_BIT = 7;
    localparam int IC2_CMPPF_BIT = 6;
    localparam int IC2_EEF_BIT = 5;
    localparam int IC2_CONVF_BIT = 4;
    localparam int IC2_CMPAE_BIT = 3;
    localparam int IC2_CMPPE_BIT = 2;
    localparam int IC2_EEE_BIT = 1;
    localparam int IC2_CONVE_BIT = 0;
    localparam int IC3_TB1F_BIT = 5;
    localparam int IC3_TB0F_BIT = 4;
    localparam int IC3_TB1E_BIT = 1;
    localparam int IC3_TB0E_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SDC_RST = 8'h00;
    localparam logic [1:0] PES_RST = 2'h0;
    localparam logic [8:0] FLAGS_RST = 9'h000;
    localparam logic [8:0] ENABLES_RST = 9'h000;
    localparam logic EMI_RST = 1'b0;

    // ------------------------------------------------------------
    // source indices, lower index wins arbitration
    // ------------------------------------------------------------
    localparam int NSRC = 9;
    localparam logic [3:0] SRC_PIN = 4'h0;
    localparam logic [3:0] SRC_SER = 4'h1;
    localparam logic [3:0] SRC_LOW = 4'h2;
    localparam logic [3:0] SRC_CMPP = 4'h3;
    localparam logic [3:0] SRC_CMPA = 4'h4;
    localparam logic [3:0] SRC_EE = 4'h5;
    localparam logic [3:0] SRC_CONV = 4'h6;
    localparam logic [3:0] SRC_TB0 = 4'h7;
    localparam logic [3:0] SRC_TB1 = 4'h8;

    // ------------------------------------------------------------
    // timing: low-supply interrupt delay
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_LVD_NS = 15000;
    localparam int LVD_CNT = (T_LVD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LVD_CW = $clog2(LVD_CNT + 1);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic serial;
        logic conv;
        logic eeprom;
        logic cmp_a;
        logic cmp_p;
        logic tb0;
        logic tb1;
    } isd_evt_t;

    typedef struct packed {
        logic [2:0] addr;
        logic wr;
        logic [7:0] wdata;
    } isd_regreq_t;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b01,
        ARB_OFFER = 2'b10
    } isd_arb_t;

    // trip level in millivolts; code 0 is reserved and reads as 0
    function automatic logic [12:0] isd_trip_mv(input logic [2:0] code);
        case (code)
            3'h1: isd_trip_mv = 13'h898; // 2200
            3'h2: isd_trip_mv = 13'h960; // 2400
            3'h3: isd_trip_mv = 13'hA8C; // 2700
            3'h4: isd_trip_mv = 13'hBB8; // 3000
            3'h5: isd_trip_mv = 13'hCE4; // 3300
            3'h6: isd_trip_mv = 13'hE10; // 3600
            3'h7: isd_trip_mv = 13'hFA0; // 4000
            default: isd_trip_mv = 13'h000;
        endcase
    endfunction

endpackage

// File: verif/isd_cpu_model.sv
// core and supply comparator stand-in facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module isd_cpu_model (
    input wire logic i_core_clk,
    input wire logic i_irq_req,
    input wire logic i_det_on,
    input wire logic [12:0] i_trip_mv,
    input wire logic [12:0] i_vdd_mv,
    output logic o_supply_low,
    output logic o_irq_ack
);
    logic ack_r = 1'b0;
    logic [1:0] wait_r = 2'h0;
    // a switched-off comparator reports no low supply
    assign o_supply_low = i_det_on && (i_vdd_mv < i_trip_mv);
    assign o_irq_ack = ack_r;
    // slow core: takes an offer only after it has stood three cycles
    always @(posedge i_core_clk) begin
        ack_r <= 1'b0;
        wait_r <= 2'h0;
        if (i_irq_req && !ack_r) begin
            wait_r <= wait_r + 2'h1;
            ack_r <= (wait_r == 2'h2);
        end
    end
endmodule
`default_nettype wire

// File: verif/isd_ctrl_tb_top.sv
// self-checking bench for the interrupt controller with supply detector
`timescale 1ns/1ps
`default_nettype none
module isd_ctrl_tb_top;
    import isd_pkg::*;
    typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} isd_row_t;
    logic clk = 1'b0, rst = 1'b1, sleep = 1'b0, rlvl = 1'b0, pin = 1'b0, full = 1'b0, ce = 1'b1;
    logic low, ack, req, wake, det, bg;
    logic [7:0] rdata;
    logic [3:0] vec;
    logic [2:0] lvl;
    logic [12:0] mv, vdd = 13'hFFF;
    isd_regreq_t regq = '0;
    isd_evt_t evt = '0;
    int err_count = 0, samples_checked = 0, cycles = 0;
    // read-only and unimplemented bits must come back as zero
    isd_row_t rows[10] = '{'{REG_SDC, 8'hEF, 8'h0F}, '{REG_PES, 8'hFF, 8'h03}, '{REG_IC1, 8'hFE, 8'h7E},
        '{REG_IC2, 8'hFF, 8'hFF}, '{REG_IC3, 8'hFF, 8'h33}, '{3'h7, 8'hFF, 8'h00}, '{REG_SDC, 8'h00, 8'h00},
        '{REG_IC1, 8'h00, 8'h00}, '{REG_IC2, 8'h00, 8'h00}, '{REG_IC3, 8'h00, 8'h00}};
    isd_ctrl dut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_reg(regq), .o_reg_rdata(rdata),
        .i_supply_low(low), .i_sleep(sleep), .i_rlvl_enable(rlvl), .i_ext_pin(pin), .i_evt(evt),
        .i_stack_full(full), .i_irq_ack(ack), .o_irq_req(req), .o_irq_vector(vec), .o_wake(wake),
        .o_detector_on(det), .o_bandgap_on(bg), .o_trip_level(lvl), .o_trip_mv(mv));
    isd_cpu_model cpu (.i_core_clk(clk), .i_irq_req(req), .i_det_on(det), .i_trip_mv(mv),
        .i_vdd_mv(vdd), .o_supply_low(low), .o_irq_ack(ack));
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        regq = '{addr: a, wr: 1'b1, wdata: d};
        @(negedge clk);
        regq.wr = 1'b0;
    endtask
    // read data lags the address by one edge
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(negedge clk);
        regq.addr = a;
        @(negedge clk);
        chk("register", {5'h0, e}, {5'h0, rdata});
    endtask
    task automatic wait_for(input logic v);
        for (int i = 0; i < 20 && req !== v; i++) @(negedge clk);
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    // hang guard, far above the expected run of about 800 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // simultaneous comparator P and conversion requests
        wr(REG_IC2, 8'h05);
        evt.cmp_p = 1'b1;
        evt.conv = 1'b1;
        @(negedge clk);
        evt = '0;
        wr(REG_IC1, 8'h01);
        wait_for(1'b1);
        chk("vector", 13'(SRC_CMPP), 13'(vec));
        wait_for(1'b0);
        repeat (3) @(negedge clk);
        chk("offer", 13'h0, 13'(req));
        rd(REG_IC1, 8'h00);
        rd(REG_IC2, 8'h15);
        chk("wake", 13'h1, 13'(wake));
        full = 1'b1;
        wr(REG_IC1, 8'h01);
        repeat (5) @(negedge clk);
        chk("offer", 13'h0, 13'(req));
        full = 1'b0;
        wait_for(1'b1);
        chk("vector", 13'(SRC_CONV), 13'(vec));
        wait_for(1'b0);
        wr(REG_IC2, 8'h00);
        // every edge mode, rising then falling
        for (int m = 0; m < 4; m++) begin
            wr(REG_PES, 8'(m));
            pin = 1'b1;
            repeat (2) @(negedge clk);
            rd(REG_IC1, m[0] ? 8'h10 : 8'h00);
            wr(REG_IC1, 8'h00);
            pin = 1'b0;
            repeat (2) @(negedge clk);
            rd(REG_IC1, m[1] ? 8'h10 : 8'h00);
            wr(REG_IC1, 8'h00);
        end
        // frozen core ignores writes and events, then every event source sets its own flag
        ce = 1'b0;
        evt = '1;
        wr(REG_IC2, 8'hFF);
        evt = '0;
        ce = 1'b1;
        rd(REG_IC2, 8'h00);
        evt = '1;
        @(negedge clk);
        evt = '0;
        rd(REG_IC2, 8'hF0);
        rd(REG_IC3, 8'h30);
        rd(REG_IC1, 8'h20);
        wr(REG_IC2, 8'h00);
        wr(REG_IC3, 8'h00);
        wr(REG_IC1, 8'h00);
        // supply just under the 3.0 V level
        vdd = 13'hB54;
        wr(REG_SDC, 8'h14);
        repeat (4) @(negedge clk);
        rd(REG_SDC, 8'h34);
        chk("trip_mv", 13'hBB8, mv);
        chk("trip_level", 13'h4, 13'(lvl));
        chk("bandgap", 13'h1, 13'(bg));
        repeat (540) @(negedge clk);
        rd(REG_IC1, 8'h00);
        repeat (70) @(negedge clk);
        rd(REG_IC1, 8'h40);
        sleep = 1'b1;
        repeat (2) @(negedge clk);
        chk("detector", 13'h0, 13'(det));
        chk("wake", 13'h1, 13'(wake));
        sleep = 1'b0;
        wr(REG_SDC, 8'h00);
        rlvl = 1'b1;
        repeat (2) @(negedge clk);
        chk("bandgap", 13'h1, 13'(bg));
        chk("trip_mv", 13'h0, mv);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk("wake", 13'h0, 13'(wake));
        rst = 1'b0;
        rd(REG_IC1, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
